/* File: core/cps_pkg.sv */
package cps_pkg;
    // timebase: one system clock cycle in ns at 25 MHz
    localparam int CLK_NS        = 40;
    // longest gate off-time before a forced turn-on, in ns
    localparam int RESTART_NS    = 150000;
    // least time after a gate rise before a zero-current edge counts, in ns
    localparam int BLANK_NS      = 3300;
    // off-time counts, rounded down for the longest wait
    localparam int RESTART_CYC_I = RESTART_NS / CLK_NS;
    // blanking counts, rounded up because it is a least time
    localparam int BLANK_CYC_I   = (BLANK_NS + CLK_NS - 1) / CLK_NS;
    localparam logic [11:0] RESTART_LAST = 12'(RESTART_CYC_I - 1);
    localparam logic [6:0]  BLANK_CYC    = 7'(BLANK_CYC_I);
    // number of asynchronous comparator flags in the shared synchroniser bank
    localparam int SYNC_W = 13;

    // switching sequencer states
    typedef enum logic [1:0] {
        ST_IDLE = 2'b00,   // inhibited, gate held off
        ST_OFF  = 2'b01,   // gate off, waiting for valley or restart
        ST_ON   = 2'b10    // gate on-period
    } cps_state_e;

    // the whole state of the sequencer
    typedef struct packed {
        cps_state_e  state;     // sequencer state
        logic        enabled;   // supply above start, not yet below stop
        logic        ovp2_lat;  // secondary over-voltage latched
        logic        ovp2_cyc;  // supply dropped below stop while latched
        logic        zcd_flag;  // hysteretic zero-current flag
        logic        zcd_prev;  // previous zero-current flag
        logic        rdy;       // ready level (1 = released)
        logic        rdy_oe;    // ready pin sinking
        logic        low_pwr;   // reduced-consumption request
        logic        gate;      // gate command
        logic [11:0] off_cnt;   // off-time counter
        logic [6:0]  blank_cnt; // blanking counter after gate rise
    } cps_state_s;

    localparam cps_state_s ST_RESET = '0;
endpackage

/* File: core/cps_sync.sv */
// two-flop synchroniser bank for the comparator flags
module cps_sync #(
    parameter int W = 1                 // number of flags
) (
    input  wire logic         sys_clk_i, // system clock
    input  wire logic         arst_n_i,  // async reset, active low
    input  wire logic         ce_i,      // clock enable
    input  wire logic [W-1:0] async_i,   // raw flags
    output logic      [W-1:0] sync_o     // synchronised flags
);
    logic [W-1:0] meta_reg;              // first stage, read only by second

    // both stages freeze with the clock enable like the sequencer state register
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            meta_reg <= '0;
            sync_o   <= '0;
        end else if (ce_i) begin
            meta_reg <= async_i;
            sync_o   <= meta_reg;
        end
    end
endmodule // cps_sync

/* File: core/cps_pfc_switch_control.sv */
module cps_pfc_switch_control (
    input  wire logic sys_clk_i,      // system clock, 25 MHz
    input  wire logic arst_n_i,       // async reset, active low
    input  wire logic ce_i,           // clock enable, freezes all state except the constant ready drive flop when low
    input  wire logic vcc_start_i,    // supply above start level
    input  wire logic vcc_stop_i,     // supply below stop level
    input  wire logic vcc_rdy_low_i,  // supply below ready hold level
    input  wire logic vcc_alive_i,    // supply above pin-drive level
    input  wire logic ovp1_i,         // output-sense over-voltage (hysteretic)
    input  wire logic sense_dis_i,    // output-sense below disable level (hysteretic)
    input  wire logic ovp2_i,         // secondary over-voltage input above threshold
    input  wire logic ovp2_clr_i,     // secondary over-voltage input below hysteresis
    input  wire logic zcd_hi_i,       // zero-current input above upper level
    input  wire logic zcd_lo_i,       // zero-current input below lower level
    input  wire logic ton_end_i,      // ramp reached error-amp output
    input  wire logic ocp_i,          // current sense above over-current level
    input  wire logic rdy_hi_i,       // output sense above ready-set level
    input  wire logic rdy_lo_i,       // output sense below ready-clear level
    output logic      gate_o,         // gate command to driver
    output logic      rdy_out_o,      // ready pin drive value (always low)
    output logic      rdy_oe_o,       // ready pin sinks while high
    output logic      low_power_o,    // reduced-consumption request
    output logic      enabled_o,      // supply lockout released
    output logic      ovp2_latched_o, // secondary over-voltage latched
    output logic      zcd_flag_o      // zero-current flag
);
    logic [cps_pkg::SYNC_W-1:0] sync_w;   // synchronised flag bundle
    logic start_s;                        // synced start level
    logic stop_s;                         // synced stop level
    logic vlow_s;                         // synced ready hold level
    logic alive_s;                        // synced pin-drive level
    logic ovp1_s;                         // synced primary over-voltage
    logic dis_s;                          // synced disable
    logic ovp2_s;                         // synced secondary over-voltage
    logic ovp2c_s;                        // synced secondary clear
    logic zhi_s;                          // synced zero-current upper
    logic zlo_s;                          // synced zero-current lower
    logic tend_s;                         // synced on-time end
    logic ocp_s;                          // synced over-current
    logic rhi_s;                          // synced ready set
    logic rlo_s;                          // synced ready clear
    cps_pkg::cps_state_s st_reg;          // registered state
    cps_pkg::cps_state_s st_next;         // next state
    logic inhibit;                        // any condition that blocks the gate
    logic zcd_fall;                       // valid falling edge of zero-current flag
    logic timeout;                        // off-time restart expiry

    // all comparator flags come from the analog domain, so two flops each
    cps_sync #(
        .W (cps_pkg::SYNC_W)
    ) u_sync (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .async_i   ({vcc_start_i, vcc_stop_i, vcc_rdy_low_i, ovp1_i, sense_dis_i,
                     ovp2_i, ovp2_clr_i, zcd_hi_i, zcd_lo_i, ton_end_i, ocp_i,
                     rdy_hi_i, rdy_lo_i}),
        .sync_o    (sync_w)
    );

    assign {start_s, stop_s, vlow_s, ovp1_s, dis_s, ovp2_s, ovp2c_s,
            zhi_s, zlo_s, tend_s, ocp_s, rhi_s, rlo_s} = sync_w;

    // supply-alive flag kept on its own two flops since it powers the pin logic
    cps_sync #(
        .W (1)
    ) u_sync_alive (
        .sys_clk_i (sys_clk_i),
        .arst_n_i  (arst_n_i),
        .ce_i      (ce_i),
        .async_i   (vcc_alive_i),
        .sync_o    (alive_s)
    );

    // primary over-voltage is a plain level here: no latch, so the gate
    // comes back on its own once the comparator drops, at the next valid valley or restart timer expiry
    assign inhibit  = !st_reg.enabled || dis_s || ovp1_s || st_reg.ovp2_lat
                      || ocp_s;
    // edges inside the blanking window are thrown away, not deferred
    assign zcd_fall = st_reg.zcd_prev && !st_reg.zcd_flag
                      && (st_reg.blank_cnt == 7'h00);
    assign timeout  = (st_reg.off_cnt == cps_pkg::RESTART_LAST);

    // next-state logic for the whole sequencer
    always_comb begin
        st_next = st_reg;

        // supply lockout with start/stop hysteresis
        if (start_s) begin
            st_next.enabled = 1'b1;
        end else if (stop_s) begin
            st_next.enabled = 1'b0;
        end

        // secondary over-voltage: the supply must cycle before release;
        // set wins over clear so a trip in the clearing cycle is kept
        if (st_reg.ovp2_lat && stop_s) begin
            st_next.ovp2_cyc = 1'b1;
        end
        if (ovp2_s) begin
            st_next.ovp2_lat = 1'b1;
        end else if (st_reg.ovp2_lat && st_reg.ovp2_cyc && st_reg.enabled && ovp2c_s) begin
            st_next.ovp2_lat = 1'b0;
            st_next.ovp2_cyc = 1'b0;
        end

        // zero-current flag: two comparators form the hysteresis
        st_next.zcd_prev = st_reg.zcd_flag;
        if (zhi_s) begin
            st_next.zcd_flag = 1'b1;
        end else if (zlo_s) begin
            st_next.zcd_flag = 1'b0;
        end

        // ready level depends on output sense and supply only, not on switching
        if (vlow_s) begin
            st_next.rdy = 1'b0;
        end else if (rhi_s) begin
            st_next.rdy = 1'b1;
        end else if (rlo_s) begin
            st_next.rdy = 1'b0;
        end
        // the pin stays floating until the supply can drive it
        st_next.rdy_oe = alive_s && !st_next.rdy;

        // disabled controller asks the rest of the chip to power down
        st_next.low_pwr = dis_s;

        // blanking counter runs down after each gate rise
        if (st_reg.blank_cnt != 7'h00) begin
            st_next.blank_cnt = st_reg.blank_cnt - 7'h01;
        end

        // switching sequencer
        case (st_reg.state)
            cps_pkg::ST_IDLE: begin
                st_next.off_cnt = 12'h000;
                if (!inhibit) begin
                    // first turn-on comes from the restart timer or a valid valley
                    st_next.state = cps_pkg::ST_OFF;
                end
            end
            cps_pkg::ST_OFF: begin
                st_next.off_cnt = st_reg.off_cnt + 12'h001;
                if (inhibit) begin
                    st_next.state = cps_pkg::ST_IDLE;
                end else if (zcd_fall || timeout) begin
                    st_next.state     = cps_pkg::ST_ON;
                    st_next.off_cnt   = 12'h000;
                    st_next.blank_cnt = cps_pkg::BLANK_CYC;
                end
            end
            cps_pkg::ST_ON: begin
                if (inhibit) begin
                    st_next.state = cps_pkg::ST_IDLE;
                end else if (tend_s) begin
                    st_next.state = cps_pkg::ST_OFF;
                end
            end
            default: begin
                st_next.state = cps_pkg::ST_IDLE;
            end
        endcase

        // gate only while the on-state holds and nothing inhibits
        st_next.gate = (st_next.state == cps_pkg::ST_ON) && !inhibit;
    end

    // single state register, frozen while the clock enable is low
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            st_reg <= cps_pkg::ST_RESET;
        end else if (ce_i) begin
            st_reg <= st_next;
        end
    end

    // outputs are direct state bits; the ready drive value is a constant low
    // held in a flop so the pin only ever sinks
    always_ff @(posedge sys_clk_i or negedge arst_n_i) begin
        if (!arst_n_i) begin
            rdy_out_o <= 1'b0;
        end else begin
            rdy_out_o <= 1'b0;
        end
    end

    assign gate_o         = st_reg.gate;
    assign rdy_oe_o       = st_reg.rdy_oe;
    assign low_power_o    = st_reg.low_pwr;
    assign enabled_o      = st_reg.enabled;
    assign ovp2_latched_o = st_reg.ovp2_lat;
    assign zcd_flag_o     = st_reg.zcd_flag;

    // expiry of the off-time counter with no inhibit
    sequence s_off_expire;
        ce_i && st_reg.state == cps_pkg::ST_OFF && timeout && !inhibit;
    endsequence

    // off-state cycle still inside blanking after a gate rise, whether or not an edge comes
    sequence s_blanked_edge;
        ce_i && st_reg.state == cps_pkg::ST_OFF && st_reg.blank_cnt != 7'h00
        && !timeout;
    endsequence

    a_lockout_gate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && !st_reg.enabled |=> !gate_o)
        else $error("gate on while supply lockout active");
    a_ovp1_gate: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && ovp1_s |=> !gate_o)
        else $error("gate on during primary over-voltage");
    a_ovp1_no_latch: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && ovp1_s && !ovp2_s && !st_reg.ovp2_lat |=> !st_reg.ovp2_lat)
        else $error("primary over-voltage latched");
    a_disable_power: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && dis_s |=> low_power_o && !gate_o)
        else $error("disable did not stop and power down");
    a_ovp2_hold: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && st_reg.ovp2_lat && !st_reg.ovp2_cyc |=> ovp2_latched_o && !gate_o)
        else $error("secondary over-voltage released without supply cycle");
    // the second step must not see a low supply or a lone clear, which pull ready down
    a_rdy_levels: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && rhi_s && !vlow_s ##1 ce_i && alive_s && !vlow_s && (rhi_s || !rlo_s)
        |=> !rdy_oe_o)
        else $error("ready not released above set level");
    a_rdy_supply: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && vlow_s |=> !st_reg.rdy)
        else $error("ready high with low supply");
    a_rdy_float: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && !alive_s |=> !rdy_oe_o)
        else $error("ready pin sinks before supply alive");
    a_restart_fire: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        s_off_expire |=> gate_o && st_reg.blank_cnt == cps_pkg::BLANK_CYC)
        else $error("restart timer did not turn gate on");
    a_blank_ignore: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        s_blanked_edge |=> !gate_o)
        else $error("edge inside blanking turned gate on");
    a_on_end: assert property (@(posedge sys_clk_i) disable iff (!arst_n_i)
        ce_i && gate_o && tend_s |=> !gate_o)
        else $error("on-time end did not end on-period");
endmodule // cps_pfc_switch_control

/* File: verification/cps_switch_model.sv */
// behavioural power switch, boost inductor and auxiliary winding
module cps_switch_model (
    input  wire logic        sys_clk_i,  // system clock
    input  wire logic        gate_i,     // gate command from the controller
    input  wire logic [11:0] ton_cyc_i,  // cycles until the on-period limit is reached
    input  wire logic [11:0] zcd_dly_i,  // demagnetising cycles, 0 = no aux signal at all
    input  wire logic        ocp_mode_i, // on-period limited by over-current, not the ramp
    output logic             zcd_hi_o,   // aux winding above upper level
    output logic             zcd_lo_o,   // aux winding below lower level
    output logic             ton_end_o,  // ramp reached error amp
    output logic             ocp_o       // current sense above limit
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [11:0] on_cnt  = 12'h000; // cycles since gate rise
    logic [11:0] off_cnt = 12'h000; // cycles since gate fall, saturating
    logic        ring;              // aux swing above the upper level
    logic        band;              // aux inside the hysteresis band

    // counters move just after the edge, like a real switch reacting to the gate
    always @(posedge sys_clk_i) begin
        on_cnt  <= gate_i ? on_cnt + 12'h001 : 12'h000;
        off_cnt <= gate_i ? 12'h000 : ((off_cnt == 12'hfff) ? off_cnt : off_cnt + 12'h001);
    end

    // the limit flag stands until the gate drops, as the comparator would
    assign ton_end_o = gate_i && !ocp_mode_i && (on_cnt >= ton_cyc_i);
    assign ocp_o     = gate_i && ocp_mode_i && (on_cnt >= ton_cyc_i);
    // one ring after demagnetising: above upper, inside band, then below lower
    assign ring = !gate_i && (zcd_dly_i != 12'h000) && (off_cnt >= zcd_dly_i)
                  && (off_cnt < zcd_dly_i + 12'h004);
    assign band = !gate_i && (zcd_dly_i != 12'h000) && (off_cnt >= zcd_dly_i + 12'h004)
                  && (off_cnt < zcd_dly_i + 12'h008);
    assign zcd_hi_o = ring;
    assign zcd_lo_o = !ring && !band;
endmodule // cps_switch_model

/* File: verification/tb.sv */
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic        sys_clk_i = 1'b0;                          // 25 MHz system clock
    logic        arst_n_i = 1'b0;                           // reset, active low
    logic        ce_i = 1'b1;                               // clock enable
    logic        vcc_start_i = 1'b0, vcc_stop_i = 1'b0;     // supply comparators
    logic        vcc_rdy_low_i = 1'b0, vcc_alive_i = 1'b0;  // supply comparators
    logic        ovp1_i = 1'b0, sense_dis_i = 1'b0;         // output-sense flags
    logic        ovp2_i = 1'b0, ovp2_clr_i = 1'b1;          // secondary input flags
    logic        rdy_hi_i = 1'b0, rdy_lo_i = 1'b1;          // ready thresholds
    logic        zcd_hi_i, zcd_lo_i, ton_end_i, ocp_i;      // from the switch model
    logic        gate_o, rdy_out_o, rdy_oe_o, low_power_o;  // design outputs
    logic        enabled_o, ovp2_latched_o, zcd_flag_o;     // design outputs
    logic        rdy_pin;                                   // ready pin with pull-up
    logic [11:0] ton_cyc = 12'h028, zcd_dly = 12'h000;      // switch model timing
    logic        ocp_mode = 1'b0;                           // switch model limit kind
    int          errors = 0, n_tests = 0, n, m;             // counters and waits

    always #20 sys_clk_i = ~sys_clk_i;
    // open-drain ready: only a sinking driver pulls it low
    assign rdy_pin = (rdy_oe_o === 1'b1) ? rdy_out_o : 1'b1;

    cps_pfc_switch_control uut (.sys_clk_i(sys_clk_i), .arst_n_i(arst_n_i), .ce_i(ce_i),
        .vcc_start_i(vcc_start_i), .vcc_stop_i(vcc_stop_i), .vcc_rdy_low_i(vcc_rdy_low_i),
        .vcc_alive_i(vcc_alive_i), .ovp1_i(ovp1_i), .sense_dis_i(sense_dis_i),
        .ovp2_i(ovp2_i), .ovp2_clr_i(ovp2_clr_i), .zcd_hi_i(zcd_hi_i), .zcd_lo_i(zcd_lo_i),
        .ton_end_i(ton_end_i), .ocp_i(ocp_i), .rdy_hi_i(rdy_hi_i), .rdy_lo_i(rdy_lo_i),
        .gate_o(gate_o), .rdy_out_o(rdy_out_o), .rdy_oe_o(rdy_oe_o),
        .low_power_o(low_power_o), .enabled_o(enabled_o), .ovp2_latched_o(ovp2_latched_o),
        .zcd_flag_o(zcd_flag_o));
    cps_switch_model sw (.sys_clk_i(sys_clk_i), .gate_i(gate_o), .ton_cyc_i(ton_cyc),
        .zcd_dly_i(zcd_dly), .ocp_mode_i(ocp_mode), .zcd_hi_o(zcd_hi_i),
        .zcd_lo_o(zcd_lo_i), .ton_end_o(ton_end_i), .ocp_o(ocp_i));

    task automatic check(input string what, input logic exp, input logic got);
        n_tests++;
        if (got !== exp) begin
            errors++;
            $display("mismatch %s expected %b seen %b", what, exp, got);
        end
    endtask
    // inputs always change one ns after the rising edge
    task automatic cyc(input int k);
        repeat (k) @(posedge sys_clk_i);
        #1;
    endtask
    // bounded wait for gate (sel 0) or enable (sel 1) to reach a level
    task automatic wait_for(input bit sel, input logic v, input int lim, output int k);
        k = 0;
        while (((sel ? enabled_o : gate_o) !== v) && (k < lim)) begin
            cyc(1);
            k++;
        end
    endtask
    // two-cycle supply comparator pulse, then time for the sync and register stages
    task automatic kick(input bit stop);
        if (stop) vcc_stop_i = 1'b1; else vcc_start_i = 1'b1;
        cyc(2);
        vcc_stop_i = 1'b0;
        vcc_start_i = 1'b0;
        cyc(4);
    endtask
    task automatic conclude();
        $display("comparisons %0d errors %0d", n_tests, errors);
        if (errors == 0 && n_tests > 0) $display("== PASSED ==");
        else $display("== FAILED ==");
        $finish;
    endtask

    // cut a hang short; the whole run needs roughly 20000 cycles
    initial begin
        #2400000;
        errors++;
        $display("mismatch watchdog expected done seen hang");
        conclude();
    end

    initial begin
        cyc(2);
        arst_n_i = 1'b1;
        cyc(1);
        check("gate after reset", 1'b0, gate_o);
        check("ready floats unpowered", 1'b0, rdy_oe_o);
        vcc_alive_i = 1'b1;
        cyc(4);
        check("ready pin low", 1'b0, rdy_pin);
        check("enabled before start", 1'b0, enabled_o);
        kick(1'b0);
        check("enabled", 1'b1, enabled_o);
        wait_for(1'b0, 1'b1, 4000, n);
        check("first turn-on by restart", 1'b1, n > cps_pkg::RESTART_CYC_I - 12);
        check("first turn-on bound", 1'b1, n < cps_pkg::RESTART_CYC_I + 4);
        wait_for(1'b0, 1'b0, 100, n);
        check("on-time end", 1'b1, n >= 40 && n <= 45);
        zcd_dly = 12'h032;
        wait_for(1'b0, 1'b1, 400, n);
        check("valley turn-on", 1'b1, n >= 58 && n <= 70);
        ton_cyc = 12'h00a;
        zcd_dly = 12'h014;
        wait_for(1'b0, 1'b0, 100, n);
        wait_for(1'b0, 1'b1, 300, n);
        check("early valley ignored", 1'b1, n == 300);
        wait_for(1'b0, 1'b1, 4000, m);
        check("forced turn-on", 1'b1, (n + m) >= cps_pkg::RESTART_CYC_I - 3);
        check("forced turn-on bound", 1'b1, (n + m) <= cps_pkg::RESTART_CYC_I + 4);
        ton_cyc = 12'h028;
        zcd_dly = 12'h032;
        ocp_mode = 1'b1;
        wait_for(1'b0, 1'b0, 100, n);
        // aux ring: flag rises, holds inside the band, then falls below lower level
        cyc(53);
        check("zcd flag above upper", 1'b1, zcd_flag_o);
        cyc(5);
        check("zcd flag held in band", 1'b1, zcd_flag_o);
        cyc(3);
        check("zcd flag below lower", 1'b0, zcd_flag_o);
        wait_for(1'b0, 1'b1, 400, n);
        wait_for(1'b0, 1'b0, 100, n);
        check("over-current ends on-time", 1'b1, n >= 40 && n <= 45);
        ocp_mode = 1'b0;
        wait_for(1'b0, 1'b1, 400, n);
        ovp1_i = 1'b1;
        wait_for(1'b0, 1'b0, 5, n);
        check("ovp1 cuts gate", 1'b1, n <= 4);
        wait_for(1'b0, 1'b1, 300, n);
        check("ovp1 holds off", 1'b1, n == 300);
        ovp1_i = 1'b0;
        wait_for(1'b0, 1'b1, 4000, n);
        check("ovp1 self recovery", 1'b1, gate_o);
        sense_dis_i = 1'b1;
        cyc(4);
        check("low power", 1'b1, low_power_o);
        wait_for(1'b0, 1'b1, 300, n);
        check("disabled holds off", 1'b1, n == 300 && gate_o === 1'b0);
        sense_dis_i = 1'b0;
        cyc(4);
        check("low power left", 1'b0, low_power_o);
        wait_for(1'b0, 1'b1, 4000, n);
        check("disable recovery", 1'b1, gate_o);
        ovp2_clr_i = 1'b0;
        ovp2_i = 1'b1;
        cyc(2);
        ovp2_i = 1'b0;
        cyc(4);
        check("ovp2 latched", 1'b1, ovp2_latched_o);
        wait_for(1'b0, 1'b1, 300, n);
        check("ovp2 holds off", 1'b1, n == 300);
        kick(1'b0);
        check("start alone keeps latch", 1'b1, ovp2_latched_o);
        kick(1'b1);
        check("stop disables", 1'b0, enabled_o);
        kick(1'b0);
        check("pin above hysteresis keeps latch", 1'b1, ovp2_latched_o);
        kick(1'b1);
        ovp2_clr_i = 1'b1;
        kick(1'b0);
        check("supply recycle clears latch", 1'b0, ovp2_latched_o);
        wait_for(1'b0, 1'b1, 4000, n);
        check("ovp2 recovery", 1'b1, gate_o);
        rdy_hi_i = 1'b1;
        rdy_lo_i = 1'b0;
        cyc(4);
        check("ready released", 1'b1, rdy_pin);
        rdy_hi_i = 1'b0;
        kick(1'b1);
        check("ready in band after stop", 1'b1, rdy_pin);
        check("gate after stop", 1'b0, gate_o);
        rdy_lo_i = 1'b1;
        cyc(4);
        check("ready below lower level", 1'b0, rdy_pin);
        rdy_lo_i = 1'b0;
        rdy_hi_i = 1'b1;
        cyc(4);
        check("ready set again", 1'b1, rdy_pin);
        vcc_rdy_low_i = 1'b1;
        cyc(4);
        check("ready low on low supply", 1'b0, rdy_pin);
        vcc_alive_i = 1'b0;
        cyc(4);
        check("ready floats unpowered", 1'b0, rdy_oe_o);
        // a low clock enable must freeze the synchronisers and the pin state
        ce_i = 1'b0;
        vcc_alive_i = 1'b1;
        cyc(6);
        check("ready frozen while clock disabled", 1'b0, rdy_oe_o);
        ce_i = 1'b1;
        cyc(4);
        check("ready sinks after clock enable", 1'b1, rdy_oe_o);
        conclude();
    end
endmodule // tb
